// ---- common/usdp_pkg.sv ----
// Constants, register map and carrier types for the UART shadow data port.
// Assumes a 250 MHz core clock and a 32-bit Avalon-MM slave port with byte addresses.
package usdp_pkg;

   // Clock and serial timing
   localparam int CLK_HZ     = 250_000_000;           // Core clock rate in Hz
   localparam int BAUD_RATE  = 115_200;               // Default line rate in bits per second
   localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;    // Core cycles per serial bit
   localparam int FIFO_DEPTH = 16;                    // Default FIFO depth in characters
   localparam int DATA_BITS  = 8;                     // Character width

   // Register map, byte addresses
   localparam logic [31:0] SHADOW_BASE   = 32'h5000_1030;  // First of sixteen aliased data words
   localparam logic [31:0] SHADOW_ALIAS1 = 32'h5000_1034;  // Alias 1 of the shadow data word
   localparam int          SHADOW_WORDS  = 16;             // Number of aliased words
   localparam logic [31:0] SHADOW_END    = 32'h5000_1070;  // First byte past the alias block
   localparam logic [31:0] CTRL_ADDR     = 32'h5000_1080;  // Mode control
   localparam logic [31:0] STAT_ADDR     = 32'h5000_1084;  // Line status view
   localparam logic [31:0] IRQ_STAT_ADDR = 32'h5000_1088;  // Sticky event bits, write one to clear
   localparam logic [31:0] IRQ_MASK_ADDR = 32'h5000_108c;  // Event enables

   // Field positions
   localparam int CTRL_FIFO_EN_BIT = 0;   // FIFO enable, as fifo_control_register bit 0
   localparam int CTRL_IR_MODE_BIT = 1;   // Infrared mode select
   localparam int STAT_DR_BIT      = 0;   // data_ready_flag
   localparam int STAT_OVR_BIT     = 1;   // Overrun error, cleared on status read
   localparam int STAT_TX_HOLDING_EMPTY_FLAG_BIT    = 5;   // tx_holding_empty_flag
   localparam int STAT_TXFULL_BIT  = 6;   // Transmit FIFO full
   localparam int IRQ_RX_BIT       = 0;   // Character received
   localparam int IRQ_OVR_BIT      = 1;   // Overrun
   localparam int IRQ_TX_HOLDING_EMPTY_FLAG_BIT     = 2;   // Holding path went empty
   localparam int IRQ_BITS         = 3;   // Number of event bits

   // Reset values
   localparam logic [15:0] SHADOW_RESET = 16'h0000;  // Shadow data word
   localparam logic [1:0]  CTRL_RESET   = 2'h0;      // FIFOs off, normal mode
   localparam logic [2:0]  MASK_RESET   = 3'h0;      // All events masked

   // Avalon-MM request from the master
   typedef struct packed {
      logic        read;        // Read strobe
      logic        write;       // Write strobe
      logic [31:0] address;     // Byte address
      logic [31:0] writedata;   // Write data
      logic [3:0]  byteenable;  // Byte lanes
   } usdp_avl_req_t;

   // Serial inputs from the pins
   typedef struct packed {
      logic sin;     // Normal serial input
      logic sir_in;  // Infrared input, high pulse marks a zero bit
   } usdp_ser_in_t;

   // Serial engine states
   typedef enum logic [1:0] {
      USDP_IDLE  = 2'b00,
      USDP_START = 2'b01,
      USDP_DATA  = 2'b10,
      USDP_STOP  = 2'b11
   } usdp_ser_state_t;

endpackage : usdp_pkg

// ---- rtl/usdp_shadow_port.sv ----
// UART shadow data port: aliased receive/transmit data word with FIFOs and a simple serial engine.
// Assumes an Avalon-MM master that holds each request until waitrequest is sampled low,
// asynchronous pin inputs, and any FIFO depth of one or more.
//
// What this block does
// - Sixteen aliased words reach the data path.
// - Read returns last character from selected input.
// - FIFOs off: new character overwrites, flags overrun.
// - FIFOs on: read returns oldest FIFO entry.
// - Full receive FIFO drops arrival, flags overrun.
// - Written character goes out on selected output.
// - FIFOs off: one write clears holding-empty.
// - FIFOs off: extra write overwrites pending character.
// - FIFOs on: accept up to depth writes.
// - Write to full transmit FIFO is dropped.
`timescale 1ns/100ps
module usdp_shadow_port #(
   parameter int DEPTH      = usdp_pkg::FIFO_DEPTH,   // FIFO depth in characters
   parameter int BIT_CYCLES = usdp_pkg::BIT_CYCLES    // Core cycles per serial bit
) (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   reset_n,
   // Avalon-MM slave
   input  wire usdp_pkg::usdp_avl_req_t avs_req,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   // Serial pins
   input  wire usdp_pkg::usdp_ser_in_t ser_in,
   output logic                        sout,
   output logic                        sir_out_n,
   // Interrupt
   output logic                        irq
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;   // Pointer width
   localparam int CW = $clog2(DEPTH + 1);                 // Count width
   localparam int BW = $clog2(BIT_CYCLES + 1);            // Bit timer width
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);   // Last slot index
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);       // FIFO full count
   localparam logic [CW-1:0] CNT_ONE  = CW'(1);           // Single holding slot
   localparam logic [BW-1:0] TMR_FULL = BW'(BIT_CYCLES - 1);  // One bit period
   localparam logic [BW-1:0] TMR_HALF = BW'(BIT_CYCLES / 2);  // Half a bit period

   // All state of the block
   typedef struct packed {
      logic                      waitreq;     // Avalon waitrequest
      logic [31:0]               rdata;       // Avalon read data
      logic                      pend_pop;    // Latched read will pop the receive head
      logic                      fifo_en;     // FIFO mode
      logic                      ir_mode;     // Infrared mode
      logic [2:0]                irq_mask;    // Event enables
      logic [2:0]                irq_stat;    // Sticky events
      logic                      ovr_flag;    // Overrun shown in line status
      logic                      irq;         // Interrupt output
      logic [DEPTH-1:0][7:0]     rx_mem;      // Receive storage
      logic [PW-1:0]             rx_rd;       // Receive head
      logic [PW-1:0]             rx_wr;       // Receive tail
      logic [CW-1:0]             rx_cnt;      // Receive fill
      logic [DEPTH-1:0][7:0]     tx_mem;      // Transmit storage
      logic [PW-1:0]             tx_rd;       // Transmit head
      logic [PW-1:0]             tx_wr;       // Transmit tail
      logic [CW-1:0]             tx_cnt;      // Transmit fill
      logic [2:0]                rx_sync;     // Pin synchroniser chain
      logic                      rx_line;     // Filtered line level
      usdp_pkg::usdp_ser_state_t rx_st;       // Receiver state
      logic [BW-1:0]             rx_tmr;      // Receiver bit timer
      logic [2:0]                rx_bit;      // Receiver bit index
      logic [7:0]                rx_shift;    // Receiver shifter
      usdp_pkg::usdp_ser_state_t tx_st;       // Transmitter state
      logic [BW-1:0]             tx_tmr;      // Transmitter bit timer
      logic [2:0]                tx_bit;      // Transmitter bit index
      logic [7:0]                tx_shift;    // Transmitter shifter
      logic                      tx_level;    // Line level being sent
      logic                      sout;        // Normal output pin
      logic                      sir_out_n;   // Infrared output pin, active low
   } usdp_state_t;

   usdp_state_t s;        // Registered state
   usdp_state_t n;        // Next state

   // Outputs straight from the state flops
   assign avs_readdata    = s.rdata;
   assign avs_waitrequest = s.waitreq;
   assign sout            = s.sout;
   assign sir_out_n       = s.sir_out_n;
   assign irq             = s.irq;

   // Next-state logic for bus, FIFOs and serial engines
   always_comb begin
      logic        req;          // Any bus request
      logic        effect;       // Edge where the request completes
      logic        shadow_hit;   // Address inside the alias block
      logic        rx_pop;       // Receive head consumed
      logic        rx_push;      // Receiver completed a character
      logic        tx_pop;       // Transmitter took the head
      logic        tx_push;      // Bus wrote a character
      logic [7:0]  rx_char;      // Completed receive character
      logic [2:0]  events;       // Events of this cycle
      logic        raw_in;       // Selected serial input
      logic        mode_change;  // FIFO mode toggled
      n           = s;
      req         = avs_req.read | avs_req.write;
      effect      = req & ~s.waitreq;
      rx_pop      = 1'b0;
      rx_push     = 1'b0;
      tx_pop      = 1'b0;
      tx_push     = 1'b0;
      rx_char     = s.rx_shift;
      events      = 3'h0;
      mode_change = 1'b0;
      // input selected by mode; infrared pulse high means a zero bit
      raw_in      = s.ir_mode ? ~ser_in.sir_in : ser_in.sin;
      shadow_hit  = (avs_req.address >= usdp_pkg::SHADOW_BASE) && (avs_req.address < usdp_pkg::SHADOW_END) &&
                    (avs_req.address[1:0] == 2'h0);

      // Bus phase one: take the request, prepare read data, drop waitrequest
      if (req && s.waitreq) begin
         n.waitreq  = 1'b0;
         n.pend_pop = 1'b0;
         if (avs_req.read) begin
            // Only a read replaces read data, so a write leaves the last answer standing
            n.rdata    = 32'h0000_0000;
            if (shadow_hit) begin
               n.rdata    = {16'h0000, 8'h00, s.rx_mem[s.rx_rd]};
               // head of FIFO; pop only what was actually shown
               n.pend_pop = (s.rx_cnt != '0);
            end else if (avs_req.address == usdp_pkg::CTRL_ADDR) begin
               n.rdata[usdp_pkg::CTRL_FIFO_EN_BIT] = s.fifo_en;
               n.rdata[usdp_pkg::CTRL_IR_MODE_BIT] = s.ir_mode;
            end else if (avs_req.address == usdp_pkg::STAT_ADDR) begin
               // data ready shows valid receive data
               n.rdata[usdp_pkg::STAT_DR_BIT]     = (s.rx_cnt != '0);
               n.rdata[usdp_pkg::STAT_OVR_BIT]    = s.ovr_flag;
               n.rdata[usdp_pkg::STAT_TX_HOLDING_EMPTY_FLAG_BIT]   = (s.tx_cnt == '0);
               n.rdata[usdp_pkg::STAT_TXFULL_BIT] = s.fifo_en ? (s.tx_cnt == CNT_FULL) : (s.tx_cnt == CNT_ONE);
            end else if (avs_req.address == usdp_pkg::IRQ_STAT_ADDR) begin
               n.rdata[usdp_pkg::IRQ_BITS-1:0] = s.irq_stat;
            end else if (avs_req.address == usdp_pkg::IRQ_MASK_ADDR) begin
               n.rdata[usdp_pkg::IRQ_BITS-1:0] = s.irq_mask;
            end else begin
               // Unmapped reads answer zero
               n.rdata = 32'h0000_0000;
            end
         end
      end else if (effect) begin
         // Bus phase two: the access takes effect on this edge
         n.waitreq = 1'b1;
         rx_pop    = s.pend_pop;
         if (avs_req.read && (avs_req.address == usdp_pkg::STAT_ADDR)) begin
            // Reading line status clears the overrun flag
            n.ovr_flag = 1'b0;
         end
         if (avs_req.write && avs_req.byteenable[0]) begin
            if (shadow_hit) begin
               // character queued for the transmitter; upper byte ignored
               tx_push = 1'b1;
            end else if (avs_req.address == usdp_pkg::CTRL_ADDR) begin
               mode_change = (avs_req.writedata[usdp_pkg::CTRL_FIFO_EN_BIT] != s.fifo_en);
               n.fifo_en   = avs_req.writedata[usdp_pkg::CTRL_FIFO_EN_BIT];
               n.ir_mode   = avs_req.writedata[usdp_pkg::CTRL_IR_MODE_BIT];
            end else if (avs_req.address == usdp_pkg::IRQ_STAT_ADDR) begin
               n.irq_stat = s.irq_stat & ~avs_req.writedata[usdp_pkg::IRQ_BITS-1:0];
            end else if (avs_req.address == usdp_pkg::IRQ_MASK_ADDR) begin
               n.irq_mask = avs_req.writedata[usdp_pkg::IRQ_BITS-1:0];
            end
         end
      end

      // Pin synchroniser; a change counts once the last two stages agree
      n.rx_sync = {s.rx_sync[1:0], raw_in};
      if (s.rx_sync[1] == s.rx_sync[2]) begin
         n.rx_line = s.rx_sync[2];
      end

      // Receiver: centre sampling off the bit timer
      n.rx_tmr = (s.rx_tmr != '0) ? s.rx_tmr - BW'(1) : s.rx_tmr;
      case (s.rx_st)
         usdp_pkg::USDP_IDLE: begin
            // Falling edge starts a frame
            if (!s.rx_line) begin
               n.rx_st  = usdp_pkg::USDP_START;
               n.rx_tmr = TMR_HALF;
            end
         end
         usdp_pkg::USDP_START: begin
            // Glitches shorter than half a bit are rejected
            if (s.rx_tmr == '0) begin
               n.rx_st  = s.rx_line ? usdp_pkg::USDP_IDLE : usdp_pkg::USDP_DATA;
               n.rx_tmr = TMR_FULL;
               n.rx_bit = 3'h0;
            end
         end
         usdp_pkg::USDP_DATA: begin
            // Least significant bit first
            if (s.rx_tmr == '0) begin
               n.rx_shift = {s.rx_line, s.rx_shift[7:1]};
               n.rx_bit   = s.rx_bit + 3'h1;
               n.rx_tmr   = TMR_FULL;
               if (s.rx_bit == 3'h7) begin
                  n.rx_st = usdp_pkg::USDP_STOP;
               end
            end
         end
         usdp_pkg::USDP_STOP: begin
            // Frames with a bad stop bit are dropped
            if (s.rx_tmr == '0) begin
               rx_push = s.rx_line;
               n.rx_st = usdp_pkg::USDP_IDLE;
            end
         end
         default: begin
            n.rx_st = usdp_pkg::USDP_IDLE;
         end
      endcase

      // Transmitter: level held for one bit per step
      n.tx_tmr = (s.tx_tmr != '0) ? s.tx_tmr - BW'(1) : s.tx_tmr;
      case (s.tx_st)
         usdp_pkg::USDP_IDLE: begin
            // Head moves to the shifter, freeing the holding path
            n.tx_level = 1'b1;
            if (s.tx_cnt != '0) begin
               tx_pop     = 1'b1;
               n.tx_shift = s.tx_mem[s.tx_rd];
               n.tx_level = 1'b0;
               n.tx_tmr   = TMR_FULL;
               n.tx_st    = usdp_pkg::USDP_START;
            end
         end
         usdp_pkg::USDP_START: begin
            if (s.tx_tmr == '0) begin
               n.tx_level = s.tx_shift[0];
               n.tx_bit   = 3'h0;
               n.tx_tmr   = TMR_FULL;
               n.tx_st    = usdp_pkg::USDP_DATA;
            end
         end
         usdp_pkg::USDP_DATA: begin
            if (s.tx_tmr == '0) begin
               n.tx_shift = {1'b1, s.tx_shift[7:1]};
               n.tx_bit   = s.tx_bit + 3'h1;
               n.tx_tmr   = TMR_FULL;
               n.tx_level = (s.tx_bit == 3'h7) ? 1'b1 : s.tx_shift[1];
               if (s.tx_bit == 3'h7) begin
                  n.tx_st = usdp_pkg::USDP_STOP;
               end
            end
         end
         usdp_pkg::USDP_STOP: begin
            if (s.tx_tmr == '0) begin
               n.tx_st = usdp_pkg::USDP_IDLE;
            end
         end
         default: begin
            n.tx_st = usdp_pkg::USDP_IDLE;
         end
      endcase
      // output pin chosen by mode; idle pin stays high
      n.sout      = s.ir_mode ? 1'b1 : n.tx_level;
      n.sir_out_n = s.ir_mode ? n.tx_level : 1'b1;

      // Receive storage; the pop is applied first so a full store that is read frees a slot
      if (rx_pop) begin
         n.rx_rd  = (s.rx_rd == PTR_LAST) ? '0 : s.rx_rd + PW'(1);
         n.rx_cnt = s.rx_cnt - CW'(1);
      end
      if (rx_push) begin
         if (!s.fifo_en && (s.rx_cnt == CNT_ONE) && !rx_pop) begin
            n.rx_mem[s.rx_rd]        = rx_char;
            events[usdp_pkg::IRQ_OVR_BIT] = 1'b1;
         end else if (s.fifo_en && (s.rx_cnt == CNT_FULL) && !rx_pop) begin
            // stored entries kept, arrival lost, overrun flagged
            events[usdp_pkg::IRQ_OVR_BIT] = 1'b1;
         end else begin
            n.rx_mem[s.rx_wr] = rx_char;
            n.rx_wr           = (s.rx_wr == PTR_LAST) ? '0 : s.rx_wr + PW'(1);
            n.rx_cnt          = n.rx_cnt + CW'(1);
         end
         events[usdp_pkg::IRQ_RX_BIT] = 1'b1;
      end

      // Transmit storage
      if (tx_pop) begin
         n.tx_rd  = (s.tx_rd == PTR_LAST) ? '0 : s.tx_rd + PW'(1);
         n.tx_cnt = s.tx_cnt - CW'(1);
      end
      if (tx_push) begin
         if (!s.fifo_en && (s.tx_cnt == CNT_ONE) && !tx_pop) begin
            n.tx_mem[s.tx_rd] = avs_req.writedata[7:0];
         end else if (s.fifo_en && (s.tx_cnt == CNT_FULL) && !tx_pop) begin
            n.tx_cnt = n.tx_cnt;
         end else begin
            n.tx_mem[s.tx_wr] = avs_req.writedata[7:0];
            n.tx_wr           = (s.tx_wr == PTR_LAST) ? '0 : s.tx_wr + PW'(1);
            n.tx_cnt          = n.tx_cnt + CW'(1);
         end
      end
      // Holding path drained by the transmitter
      if ((s.tx_cnt != '0) && (n.tx_cnt == '0)) begin
         events[usdp_pkg::IRQ_TX_HOLDING_EMPTY_FLAG_BIT] = 1'b1;
      end

      // Switching FIFO mode empties both stores, as a FIFO reset would
      if (mode_change) begin
         n.rx_rd  = '0;
         n.rx_wr  = '0;
         n.rx_cnt = '0;
         n.tx_rd  = '0;
         n.tx_wr  = '0;
         n.tx_cnt = '0;
      end

      // Sticky events; a set in the clearing cycle wins
      n.irq_stat = n.irq_stat | events;
      if (events[usdp_pkg::IRQ_OVR_BIT]) begin
         n.ovr_flag = 1'b1;
      end
      n.irq = |(n.irq_stat & n.irq_mask);
   end

   // State register; reset loads constants only
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s           <= '0;
         s.waitreq   <= 1'b1;
         s.rdata     <= {16'h0000, usdp_pkg::SHADOW_RESET};
         s.fifo_en   <= usdp_pkg::CTRL_RESET[usdp_pkg::CTRL_FIFO_EN_BIT];
         s.ir_mode   <= usdp_pkg::CTRL_RESET[usdp_pkg::CTRL_IR_MODE_BIT];
         s.irq_mask  <= usdp_pkg::MASK_RESET;
         s.rx_sync   <= 3'h7;
         s.rx_line   <= 1'b1;
         s.tx_level  <= 1'b1;
         s.sout      <= 1'b1;
         s.sir_out_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

endmodule : usdp_shadow_port

// ---- sim/usdp_ser_model.sv ----
// Remote serial transceiver facing the shadow data port's pins.
// Assumes 8N1 framing, LSB first, BIT_CYCLES core cycles per bit.
`timescale 1ns/100ps
module usdp_ser_model #(
   parameter int BIT_CYCLES = 16   // Core cycles per bit
) (
   // Clock
   input  wire logic            core_clk,
   // Lines from the port
   input  wire logic            sout,
   input  wire logic            sir_out_n,
   // Lines into the port
   output usdp_pkg::usdp_ser_in_t ser_in
);
   logic [7:0] got [0:31];   // Characters captured off the line
   int         got_n = 0;    // Number captured
   logic       line;         // Either output; idle output sits high

   initial ser_in = '{sin: 1'b1, sir_in: 1'b0};
   assign line = sout & sir_out_n;

   // Send one frame; the unused input stays at its idle level
   task send(input logic [7:0] b, input logic ir);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge core_clk);
         ser_in.sin    <= ir | f[i];
         ser_in.sir_in <= ir & !f[i];
         repeat (BIT_CYCLES - 1) @(posedge core_clk);
      end
   endtask : send

   initial begin : rx
      logic [7:0] b;
      forever begin
         @(negedge line);
         // Sample at mid-bit to stay clear of edge jitter
         repeat (BIT_CYCLES / 2) @(posedge core_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge core_clk);
            b[i] = line;
         end
         repeat (BIT_CYCLES) @(posedge core_clk);
         got[got_n] = b;
         got_n++;
      end
   end
endmodule : usdp_ser_model

// ---- sim/usdp_shadow_port_checker.sv ----
// Port-level assertions for the shadow data port.
// Assumes it is bound to every instance of usdp_shadow_port.
`timescale 1ns/100ps
module usdp_shadow_port_checker #(
   parameter int BIT_CYCLES = 16   // Core cycles per bit
) (
   input wire logic                   core_clk,
   input wire logic                   reset_n,
   input wire usdp_pkg::usdp_avl_req_t avs_req,
   input wire logic [31:0]            avs_readdata,
   input wire logic                   avs_waitrequest,
   input wire usdp_pkg::usdp_ser_in_t ser_in,
   input wire logic                   sout,
   input wire logic                   sir_out_n,
   input wire logic                   irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic mask_seen;   // Mask written since reset; irq must stay low before

   // Track the first mask write
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) mask_seen <= 1'b0;
      else if (!avs_waitrequest && avs_req.write && avs_req.address == usdp_pkg::IRQ_MASK_ADDR) mask_seen <= 1'b1;
   end

   wait_one_a: assert property ((avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait");
   ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge longer than one cycle");
   no_spur_a: assert property (!avs_waitrequest |-> $past(avs_req.read || avs_req.write))
      else $error("acknowledge without request");
   upper_zero_a: assert property (!avs_waitrequest && avs_req.read && avs_req.address >= usdp_pkg::SHADOW_BASE
      && avs_req.address < usdp_pkg::SHADOW_END |-> avs_readdata[31:8] == 24'h000000)
      else $error("shadow upper bits not zero");
   unmapped_a: assert property (!avs_waitrequest && avs_req.read && avs_req.address > 32'h5000_108c
      |-> avs_readdata == 32'h00000000)
      else $error("unmapped read not zero");
   rd_stable_a: assert property (avs_waitrequest || !avs_req.read |-> $stable(avs_readdata))
      else $error("read data changed outside a read answer");
   line_excl_a: assert property (!sout |-> sir_out_n)
      else $error("both serial outputs active");
   low_run_a: assert property ($fell(sout) |-> !sout [*8])
      else $error("serial low bit too short");
   irq_quiet_a: assert property (!mask_seen |-> !irq)
      else $error("interrupt while all events masked");
endmodule : usdp_shadow_port_checker

bind usdp_shadow_port usdp_shadow_port_checker #(.BIT_CYCLES(BIT_CYCLES)) i_usdp_shadow_port_checker (
   .core_clk(core_clk), .reset_n(reset_n), .avs_req(avs_req), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .ser_in(ser_in), .sout(sout), .sir_out_n(sir_out_n), .irq(irq));

// ---- sim/usdp_shadow_port_tb.sv ----
// Self-checking bench for the shadow data port.
// Assumes the serial model on the pins and Avalon-MM tasks below.
`timescale 1ns/100ps
module usdp_shadow_port_tb;
   localparam int BC = 16;   // Short bit time keeps the run brief
   localparam int DP = 4;    // Small FIFO so full is reached quickly
   logic                    core_clk = 1'b0;
   logic                    reset_n  = 1'b0;
   logic                    irq, sout, sir_out_n, avs_waitrequest;
   logic [31:0]             avs_readdata, q;
   usdp_pkg::usdp_avl_req_t avs_req = '0;
   usdp_pkg::usdp_ser_in_t  ser_in;
   int                      n_fail = 0, n_tests = 0, cyc = 0;

   usdp_shadow_port #(.DEPTH(DP), .BIT_CYCLES(BC)) i_usdp_shadow_port (.core_clk(core_clk), .reset_n(reset_n),
      .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ser_in(ser_in),
      .sout(sout), .sir_out_n(sir_out_n), .irq(irq));
   usdp_ser_model #(.BIT_CYCLES(BC)) i_usdp_ser_model (.core_clk(core_clk), .sout(sout),
      .sir_out_n(sir_out_n), .ser_in(ser_in));

   initial begin
      forever #2 core_clk = ~core_clk;
   end

   // Hang guard: the tests need well under this many cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         test_done();
      end
   end

   task test_done;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   // One Avalon cycle, held until waitrequest is seen low
   task bus(input logic r, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_req <= '{read: r, write: !r, address: a, writedata: d, byteenable: 4'hf};
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_req.read  <= 1'b0;
      avs_req.write <= 1'b0;
   endtask : bus

   task wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask : wr

   task rd(input logic [31:0] a);
      bus(1'b1, a, 32'h0);
   endtask : rd

   // Poll status until data ready, bounded
   task wait_dr;
      q = '0;
      for (int i = 0; i < 200 && q[0] !== 1'b1; i++) rd(usdp_pkg::STAT_ADDR);
      chk(q[0], 1'b1);
   endtask : wait_dr

   task wait_tx(input int n);
      for (int i = 0; i < 3000 && i_usdp_ser_model.got_n < n; i++) @(posedge core_clk);
      chk(i_usdp_ser_model.got_n, n);
   endtask : wait_tx

   task t_reset;
      rd(usdp_pkg::SHADOW_ALIAS1); chk(q, 32'h0);
      rd(usdp_pkg::STAT_ADDR); chk(q, 32'h20);
      rd(usdp_pkg::IRQ_MASK_ADDR); chk(q, 32'h0);
      rd(32'h5000_1090); chk(q, 32'h0);
      $display("t_reset done");
   endtask : t_reset

   task t_rx_alias;
      i_usdp_ser_model.send(8'ha5, 1'b0);
      wait_dr;
      rd(usdp_pkg::SHADOW_ALIAS1); chk(q, 32'ha5);
      i_usdp_ser_model.send(8'h5c, 1'b0);
      wait_dr;
      rd(usdp_pkg::SHADOW_END - 32'h4); chk(q, 32'h5c);
      rd(usdp_pkg::STAT_ADDR); chk(q[0], 1'b0);
      $display("t_rx_alias done");
   endtask : t_rx_alias

   task t_rx_ovr;
      i_usdp_ser_model.send(8'h11, 1'b0);
      i_usdp_ser_model.send(8'h22, 1'b0);
      wait_dr;
      // The polling read already shows overrun and clears it
      chk(q[1:0], 2'b11);
      rd(usdp_pkg::STAT_ADDR); chk(q[1], 1'b0);
      rd(usdp_pkg::SHADOW_BASE); chk(q, 32'h22);
      chk(irq, 1'b0);
      wr(usdp_pkg::IRQ_MASK_ADDR, 32'h2);
      rd(usdp_pkg::IRQ_STAT_ADDR); chk(q[1], 1'b1);
      chk(irq, 1'b1);
      wr(usdp_pkg::IRQ_STAT_ADDR, 32'h2);
      rd(usdp_pkg::IRQ_STAT_ADDR); chk(q[1], 1'b0);
      chk(irq, 1'b0);
      $display("t_rx_ovr done");
   endtask : t_rx_ovr

   task t_tx_norm;
      wr(usdp_pkg::SHADOW_ALIAS1, 32'h41);
      wr(usdp_pkg::SHADOW_ALIAS1, 32'hff42);
      rd(usdp_pkg::STAT_ADDR); chk(q[5], 1'b0);
      wr(usdp_pkg::SHADOW_ALIAS1, 32'h43);
      wait_tx(2);
      chk(i_usdp_ser_model.got[0], 8'h41);
      chk(i_usdp_ser_model.got[1], 8'h43);
      $display("t_tx_norm done");
   endtask : t_tx_norm

   task t_ir;
      wr(usdp_pkg::CTRL_ADDR, 32'h2);
      i_usdp_ser_model.send(8'h96, 1'b1);
      wait_dr;
      rd(usdp_pkg::SHADOW_ALIAS1); chk(q, 32'h96);
      wr(usdp_pkg::SHADOW_ALIAS1, 32'h69);
      wait_tx(3);
      chk(i_usdp_ser_model.got[2], 8'h69);
      wr(usdp_pkg::CTRL_ADDR, 32'h0);
      $display("t_ir done");
   endtask : t_ir

   task t_fifo_tx;
      // Shifter takes the first, the FIFO holds DP more
      wr(usdp_pkg::CTRL_ADDR, 32'h1);
      for (int i = 0; i <= DP; i++) wr(usdp_pkg::SHADOW_BASE + 4 * i, 32'h30 + i);
      rd(usdp_pkg::STAT_ADDR); chk(q[6], 1'b1);
      wr(usdp_pkg::SHADOW_BASE, 32'hee);
      wait_tx(4 + DP);
      for (int i = 0; i <= DP; i++) chk(i_usdp_ser_model.got[3 + i], 8'h30 + i);
      repeat (300) @(posedge core_clk);
      chk(i_usdp_ser_model.got_n, 4 + DP);
      $display("t_fifo_tx done");
   endtask : t_fifo_tx

   task t_fifo_rx;
      for (int i = 0; i <= DP; i++) i_usdp_ser_model.send(8'h40 + i, 1'b0);
      wait_dr;
      chk(q[1], 1'b1);
      chk(irq, 1'b1);
      for (int i = 0; i < DP; i++) begin
         rd(usdp_pkg::SHADOW_ALIAS1); chk(q, 32'h40 + i);
      end
      rd(usdp_pkg::STAT_ADDR); chk(q[0], 1'b0);
      $display("t_fifo_rx done");
   endtask : t_fifo_rx

   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      t_reset;
      t_rx_alias;
      t_rx_ovr;
      t_tx_norm;
      t_ir;
      t_fifo_tx;
      t_fifo_rx;
      test_done;
   end
endmodule : usdp_shadow_port_tb
